/* scfm_top.sv */
// Contract
// - A 32-bit reference counter runs 0 to 0x3FFFFFFF, wraps, marking one window.
// - Sample cycles are counted only while input clock valid and sample clock running.
// - The window counter advances on 200 MHz reference ticks; frequency is ratio times that.
// - Cycle total is read-only, 32 bits at 31:0, resets to zero.
// - An enabled source interrupts on each rising edge of its status bit.
// - Mask bit 3 enables lock-lost interrupt; read-write, resets 0.
// - Mask bit 2 enables locked interrupt; read-write, resets 0.
// - Mask bit 1 enables input-clock-missing interrupt; read-write, resets 0.
// - Mask bit 0 enables input-clock-present interrupt; read-write, resets 0.
// - Status bit follows its condition; the flag sets at the same moment.
// - Flags stay set until software writes 1; they ignore the mask, reset 0.
// - Clock-valid indication reads 1 while the differential input clock is valid.
module scfm_top #(
	parameter logic [31:0] WIN_MAX = scfm_pkg::WINDOW_MAX
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ref_tick_i,
	input  wire logic        sample_tick_i,
	input  wire logic        sample_run_i,
	input  wire logic        clk_valid_i,
	input  wire logic        pll_lock_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	output logic             reg_rvalid_o,
	output logic             irq_o
);
	logic        win_end;
	logic        count_en;
	logic [31:0] sample_cnt_r;
	logic [31:0] sample_cnt_nxt;
	logic [31:0] cycle_total_r;
	logic [31:0] cycle_total_nxt;
	logic [3:0]  mask_r;
	logic [3:0]  mask_nxt;
	logic [3:0]  status_r;
	logic [3:0]  status_nxt;
	logic [3:0]  flag_r;
	logic [3:0]  flag_nxt;
	logic [3:0]  rise;
	logic        valid_r;
	logic        irq_r;
	logic        irq_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        rvalid_r;

	scfm_window #(
		.WIN_MAX (WIN_MAX)
	) u_window (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.ref_tick_i (ref_tick_i),
		.win_end_o  (win_end)
	);

	assign count_en = clk_valid_i && sample_run_i && sample_tick_i;

	always_comb begin
		sample_cnt_nxt  = sample_cnt_r;
		cycle_total_nxt = cycle_total_r;
		if (win_end) begin
			// The tick in the closing cycle still belongs to the ending window.
			cycle_total_nxt = sample_cnt_r + {31'h00000000, count_en};
			sample_cnt_nxt  = 32'h00000000;
		end else if (count_en) begin
			sample_cnt_nxt = sample_cnt_r + 32'h00000001;
		end
	end

	always_comb begin
		status_nxt = 4'h0;
		status_nxt[scfm_pkg::SRC_LOCK_LOST]   = !pll_lock_i;
		status_nxt[scfm_pkg::SRC_LOCKED]      = pll_lock_i;
		status_nxt[scfm_pkg::SRC_CLK_MISSING] = !clk_valid_i;
		status_nxt[scfm_pkg::SRC_CLK_PRESENT] = clk_valid_i;
		rise = status_nxt & ~status_r;
	end

	always_comb begin
		mask_nxt = mask_r;
		if (reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_MASK) begin
			mask_nxt = reg_wdata_i[3:0];
		end
	end

	always_comb begin
		flag_nxt = flag_r;
		if (reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_FLAG) begin
			flag_nxt = flag_r & ~reg_wdata_i[3:0];
		end
		// Set is applied last so an event that lands in the clear cycle is never lost.
		flag_nxt = flag_nxt | rise;
	end

	always_comb begin
		// A pulse, not a level: the host finds the cause in the flags and no acknowledge is needed.
		irq_nxt = |(rise & mask_r);
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_i) begin
			if (reg_addr_i == scfm_pkg::OFF_CLK_STATUS) begin
				rdata_nxt = {31'h00000000, valid_r};
			end else if (reg_addr_i == scfm_pkg::OFF_CYCLE_TOTAL) begin
				rdata_nxt = cycle_total_r;
			end else if (reg_addr_i == scfm_pkg::OFF_IRQ_MASK) begin
				rdata_nxt = {28'h0000000, mask_r};
			end else if (reg_addr_i == scfm_pkg::OFF_IRQ_STATUS) begin
				rdata_nxt = {28'h0000000, status_r};
			end else if (reg_addr_i == scfm_pkg::OFF_IRQ_FLAG) begin
				rdata_nxt = {28'h0000000, flag_r};
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sample_cnt_r  <= 32'h00000000;
			cycle_total_r <= scfm_pkg::CYCLE_TOTAL_RST;
			mask_r        <= scfm_pkg::IRQ_MASK_RST;
			status_r      <= 4'h0;
			flag_r        <= scfm_pkg::IRQ_FLAG_RST;
			valid_r       <= 1'b0;
			irq_r         <= 1'b0;
			rdata_r       <= 32'h00000000;
			rvalid_r      <= 1'b0;
		end else begin
			sample_cnt_r  <= sample_cnt_nxt;
			cycle_total_r <= cycle_total_nxt;
			mask_r        <= mask_nxt;
			status_r      <= status_nxt;
			flag_r        <= flag_nxt;
			valid_r       <= clk_valid_i;
			irq_r         <= irq_nxt;
			rdata_r       <= rdata_nxt;
			rvalid_r      <= reg_rd_i;
		end
	end

	assign reg_rdata_o  = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign irq_o        = irq_r;

	property p_total_reset;
		@(posedge clk_i) !rst_n_i |=> (cycle_total_r == 32'h00000000 && mask_r == 4'h0 && flag_r == 4'h0);
	endproperty
	a_total_reset: assert property (p_total_reset) else $error("registers not zero after reset");

	property p_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		win_end |=> (cycle_total_r == $past(sample_cnt_r) + {31'h00000000, $past(count_en)}
			&& sample_cnt_r == 32'h00000000);
	endproperty
	a_load: assert property (p_load) else $error("total not loaded at window end");

	property p_gate;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!win_end && !(clk_valid_i && sample_run_i)) |=> sample_cnt_r == $past(sample_cnt_r);
	endproperty
	a_gate: assert property (p_gate) else $error("counted while input clock not ready");

	property p_irq_rise;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mask_r[scfm_pkg::SRC_CLK_PRESENT] && clk_valid_i && !status_r[scfm_pkg::SRC_CLK_PRESENT]) |=> irq_o;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("enabled rising source gave no interrupt");

	property p_irq_masked;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mask_r == 4'h0) |=> !irq_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all sources disabled");

	property p_mask_write;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_MASK) |=> mask_r == $past(reg_wdata_i[3:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

	property p_status;
		@(posedge clk_i) disable iff (!rst_n_i)
		1'b1 |=> (status_r[scfm_pkg::SRC_LOCKED] == $past(pll_lock_i)
			&& status_r[scfm_pkg::SRC_LOCK_LOST] == !$past(pll_lock_i)
			&& status_r[scfm_pkg::SRC_CLK_MISSING] == !$past(clk_valid_i));
	endproperty
	a_status: assert property (p_status) else $error("status does not follow its source");

	property p_flag_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_r[0] && !(reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_FLAG && reg_wdata_i[0])) |=> flag_r[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clear");

	property p_flag_set;
		@(posedge clk_i) disable iff (!rst_n_i)
		(pll_lock_i && !status_r[scfm_pkg::SRC_LOCKED]) |=> (flag_r[scfm_pkg::SRC_LOCKED] && status_r[scfm_pkg::SRC_LOCKED]);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set with status");

	property p_valid_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_rd_i && reg_addr_i == scfm_pkg::OFF_CLK_STATUS) |=> reg_rdata_o[0] == $past(valid_r);
	endproperty
	a_valid_read: assert property (p_valid_read) else $error("clock valid readback wrong");

	property p_irq_lock_lost;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mask_r[scfm_pkg::SRC_LOCK_LOST] && !pll_lock_i && !status_r[scfm_pkg::SRC_LOCK_LOST]) |=> irq_o;
	endproperty
	a_irq_lock_lost: assert property (p_irq_lock_lost) else $error("lock-lost interrupt missing");

	property p_irq_locked;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mask_r[scfm_pkg::SRC_LOCKED] && pll_lock_i && !status_r[scfm_pkg::SRC_LOCKED]) |=> irq_o;
	endproperty
	a_irq_locked: assert property (p_irq_locked) else $error("locked interrupt missing");

	property p_irq_missing;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mask_r[scfm_pkg::SRC_CLK_MISSING] && !clk_valid_i && !status_r[scfm_pkg::SRC_CLK_MISSING]) |=> irq_o;
	endproperty
	a_irq_missing: assert property (p_irq_missing) else $error("clock-missing interrupt missing");

	property p_irq_cause;
		@(posedge clk_i) disable iff (!rst_n_i)
		irq_o |-> (($past(mask_r) & status_r & ~$past(status_r)) != 4'h0);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without an enabled rising source");

	property p_flag_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_FLAG && reg_wdata_i[scfm_pkg::SRC_CLK_PRESENT] && !clk_valid_i)
			|=> !flag_r[scfm_pkg::SRC_CLK_PRESENT];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write of one");

	property p_flag_any;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!clk_valid_i && !status_r[scfm_pkg::SRC_CLK_MISSING]) |=> flag_r[scfm_pkg::SRC_CLK_MISSING];
	endproperty
	a_flag_any: assert property (p_flag_any) else $error("flag not set regardless of mask");

	property p_flag_hold_lost;
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_r[scfm_pkg::SRC_LOCK_LOST]
			&& !(reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_FLAG && reg_wdata_i[scfm_pkg::SRC_LOCK_LOST]))
			|=> flag_r[scfm_pkg::SRC_LOCK_LOST];
	endproperty
	a_flag_hold_lost: assert property (p_flag_hold_lost) else $error("lock-lost flag dropped without a clear");

	property p_status_present;
		@(posedge clk_i) disable iff (!rst_n_i)
		1'b1 |=> status_r[scfm_pkg::SRC_CLK_PRESENT] == $past(clk_valid_i);
	endproperty
	a_status_present: assert property (p_status_present) else $error("clock-present status wrong");

	property p_count;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!win_end && clk_valid_i && sample_run_i && sample_tick_i) |=> sample_cnt_r == $past(sample_cnt_r) + 32'h00000001;
	endproperty
	a_count: assert property (p_count) else $error("enabled sample tick not counted");

	property p_total_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!win_end |=> cycle_total_r == $past(cycle_total_r);
	endproperty
	a_total_hold: assert property (p_total_hold) else $error("total changed inside a window");

	property p_rvalid;
		@(posedge clk_i) disable iff (!rst_n_i)
		reg_rd_i |=> reg_rvalid_o;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");

	property p_total_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_rd_i && reg_addr_i == scfm_pkg::OFF_CYCLE_TOTAL) |=> reg_rdata_o == $past(cycle_total_r);
	endproperty
	a_total_read: assert property (p_total_read) else $error("total readback wrong");

	property p_total_ro;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == scfm_pkg::OFF_CYCLE_TOTAL && !win_end) |=> cycle_total_r == $past(cycle_total_r);
	endproperty
	a_total_ro: assert property (p_total_ro) else $error("write changed the read-only total");

	property p_mask_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!(reg_wr_i && reg_addr_i == scfm_pkg::OFF_IRQ_MASK) |=> mask_r == $past(mask_r);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask changed without a write");
endmodule

/* scfm_pkg.sv */
package scfm_pkg;
	localparam int          REG_AW          = 8;
	localparam int          DATA_W          = 32;
	localparam int          SRC_N           = 4;
	localparam logic [7:0]  OFF_CLK_STATUS  = 8'h04;
	localparam logic [7:0]  OFF_CYCLE_TOTAL = 8'h08;
	localparam logic [7:0]  OFF_IRQ_MASK    = 8'h0C;
	localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h10;
	localparam logic [7:0]  OFF_IRQ_FLAG    = 8'h14;
	localparam logic [31:0] WINDOW_MAX      = 32'h3FFFFFFF;
	localparam logic [31:0] CYCLE_TOTAL_RST = 32'h00000000;
	localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
	localparam logic [3:0]  IRQ_FLAG_RST    = 4'h0;
	localparam int          SRC_LOCK_LOST   = 3;
	localparam int          SRC_LOCKED      = 2;
	localparam int          SRC_CLK_MISSING = 1;
	localparam int          SRC_CLK_PRESENT = 0;
	localparam int          CLK_VALID_BIT   = 0;
	localparam longint      REF_FREQ_HZ     = 200000000;
	localparam longint      CLK_FREQ_HZ     = 20000000;
endpackage

/* scfm_window.sv */
module scfm_window #(
	parameter logic [31:0] WIN_MAX = scfm_pkg::WINDOW_MAX
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ref_tick_i,
	output logic      win_end_o
);
	logic [31:0] ref_cnt_r;
	logic [31:0] ref_cnt_nxt;
	logic        win_end_r;
	logic        win_end_nxt;

	always_comb begin
		ref_cnt_nxt = ref_cnt_r;
		win_end_nxt = 1'b0;
		if (ref_tick_i) begin
			if (ref_cnt_r == WIN_MAX) begin
				ref_cnt_nxt = 32'h00000000;
				win_end_nxt = 1'b1;
			end else begin
				ref_cnt_nxt = ref_cnt_r + 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ref_cnt_r <= 32'h00000000;
			win_end_r <= 1'b0;
		end else begin
			ref_cnt_r <= ref_cnt_nxt;
			win_end_r <= win_end_nxt;
		end
	end

	assign win_end_o = win_end_r;

	property p_wrap;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ref_tick_i && ref_cnt_r == WIN_MAX) |=> (ref_cnt_r == 32'h00000000 && win_end_r);
	endproperty
	a_wrap: assert property (p_wrap) else $error("window counter did not wrap at max");

	property p_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!ref_tick_i |=> (ref_cnt_r == $past(ref_cnt_r) && !win_end_r);
	endproperty
	a_hold: assert property (p_hold) else $error("window counter moved without a reference tick");
endmodule

/* scfm_gen_model.sv */
module scfm_gen_model (
	input  wire logic clk_i,
	input  wire logic lock_en_i,
	input  wire logic valid_en_i,
	output logic      sample_tick_o,
	output logic      sample_run_o,
	output logic      clk_valid_o,
	output logic      pll_lock_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sample_tick_o = 1'b0;
		sample_run_o = 1'b0;
		clk_valid_o = 1'b0;
		pll_lock_o = 1'b0;
	end
	// Ticks alternate, so a steady window holds exactly half its length in counts.
	always @(posedge clk_i) begin
		#5;
		clk_valid_o = valid_en_i;
		sample_run_o = valid_en_i;
		pll_lock_o = lock_en_i;
		sample_tick_o = valid_en_i & ~sample_tick_o;
	end
endmodule

/* scfm_top_tb_top.sv */
module scfm_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] WIN = 32'h0000000F;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        lock_en = 1'b0;
	logic        valid_en = 1'b0;
	logic        s_tick, s_run, c_valid, p_lock;
	logic [7:0]  reg_addr_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic        reg_rd_i = 1'b0;
	logic        ref_tick = 1'b1;
	logic        ref_slow = 1'b0;
	logic [31:0] reg_rdata_o;
	logic        reg_rvalid_o;
	logic        irq_o;
	logic [31:0] rd;
	int          bad_count = 0;
	int          check_count = 0;
	int          irq_cnt = 0;
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		#5;
		ref_tick = ref_slow ? ~ref_tick : 1'b1;
	end
	scfm_gen_model gen (.clk_i(clk_i), .lock_en_i(lock_en), .valid_en_i(valid_en), .sample_tick_o(s_tick),
		.sample_run_o(s_run), .clk_valid_o(c_valid), .pll_lock_o(p_lock));
	scfm_top #(.WIN_MAX(WIN)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ref_tick_i(ref_tick), .sample_tick_i(s_tick),
		.sample_run_i(s_run), .clk_valid_i(c_valid), .pll_lock_i(p_lock), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .irq_o(irq_o));
	always @(negedge clk_i) begin
		if (irq_o === 1'b1) begin
			irq_cnt++;
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		#5;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_i);
		#5;
		reg_wr_i = 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge clk_i);
		#5;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i);
		#5;
		reg_rd_i = 1'b0;
		n = 0;
		while (reg_rvalid_o !== 1'b1 && n < 4) begin
			@(posedge clk_i);
			#5;
			n++;
		end
		if (reg_rvalid_o !== 1'b1) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, reg_rvalid_o, 1'b1);
		end
		d = reg_rdata_o;
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		reg_read(a, v);
		check32(v, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	initial begin
		#200000;
		bad_count++;
		print_verdict();
	end
	initial begin
		idle(2);
		#5;
		rst_n_i = 1'b1;
		idle(4);
		expect_reg(scfm_pkg::OFF_CYCLE_TOTAL, 32'h00000000);
		expect_reg(scfm_pkg::OFF_IRQ_MASK, 32'h00000000);
		expect_reg(8'h20, 32'h00000000);
		expect_reg(scfm_pkg::OFF_CLK_STATUS, 32'h00000000);
		expect_reg(scfm_pkg::OFF_IRQ_STATUS, 32'h0000000A);
		expect_reg(scfm_pkg::OFF_IRQ_FLAG, 32'h0000000A);
		$display("test reset_values done");
		reg_write(scfm_pkg::OFF_CYCLE_TOTAL, 32'hFFFFFFFF);
		idle(40);
		expect_reg(scfm_pkg::OFF_CYCLE_TOTAL, 32'h00000000);
		reg_write(scfm_pkg::OFF_IRQ_MASK, 32'hFFFFFFFF);
		expect_reg(scfm_pkg::OFF_IRQ_MASK, 32'h0000000F);
		reg_write(scfm_pkg::OFF_IRQ_FLAG, 32'h0000000F);
		expect_reg(scfm_pkg::OFF_IRQ_FLAG, 32'h00000000);
		check32(irq_cnt, 32'h00000000);
		$display("test access done");
		reg_write(scfm_pkg::OFF_IRQ_MASK, 32'h00000005);
		valid_en = 1'b1;
		idle(6);
		lock_en = 1'b1;
		idle(6);
		check32(irq_cnt, 32'h00000002);
		expect_reg(scfm_pkg::OFF_IRQ_STATUS, 32'h00000005);
		expect_reg(scfm_pkg::OFF_CLK_STATUS, 32'h00000001);
		reg_write(scfm_pkg::OFF_IRQ_MASK, 32'h00000008);
		lock_en = 1'b0;
		idle(6);
		check32(irq_cnt, 32'h00000003);
		expect_reg(scfm_pkg::OFF_IRQ_FLAG, 32'h0000000D);
		$display("test interrupts done");
		idle(50);
		expect_reg(scfm_pkg::OFF_CYCLE_TOTAL, (WIN + 32'h00000001) >> 1);
		$display("test window done");
		// A reference tick on every other edge doubles the window, so the total is one count per tick.
		ref_slow = 1'b1;
		idle(100);
		expect_reg(scfm_pkg::OFF_CYCLE_TOTAL, WIN + 32'h00000001);
		$display("test slow_reference done");
		rst_n_i = 1'b0;
		idle(2);
		#5;
		rst_n_i = 1'b1;
		expect_reg(scfm_pkg::OFF_CYCLE_TOTAL, 32'h00000000);
		expect_reg(scfm_pkg::OFF_IRQ_MASK, 32'h00000000);
		expect_reg(scfm_pkg::OFF_IRQ_FLAG, 32'h00000009);
		check32(irq_cnt, 32'h00000003);
		$display("test mid_reset done");
		reg_write(scfm_pkg::OFF_IRQ_MASK, 32'h00000002);
		valid_en = 1'b0;
		idle(6);
		check32(irq_cnt, 32'h00000004);
		expect_reg(scfm_pkg::OFF_IRQ_STATUS, 32'h0000000A);
		expect_reg(scfm_pkg::OFF_CLK_STATUS, 32'h00000000);
		$display("test clock_loss done");
		print_verdict();
	end
endmodule
